// ### hdl/cpu_status_flags.v
// Purpose: Core status register with flag update and AXI4-Lite access
// Assumes: One instruction per exec_valid strobe, synchronous to ref_clk
// Notes: Software access through the bus sees the same register
//   Ready toggles while idle; a bus master must wait for it
//   Watchdog time-out beats a same-cycle kick or sleep
//
// What this block does
// - Status register may be the destination of any instruction; here only file-register ops write it, not literal add/sub, kick or sleep.
// - Flag-updating instruction aimed at status: data write to the three flags is disabled.
// - Writes to timeout and power-down flags are ignored.
// - Clearing status zeros bits 7..5, sets zero flag, keeps others.
// - Bit clear, bit set, swap and move leave arithmetic flags alone.
// - Bank bit one selects 80h-FFh, zero selects 00h-7Fh.
// - Timeout flag set at power-up, kick, sleep; cleared by time-out.
// - Power-down flag set at power-up and kick; cleared by sleep.
// - Zero flag set on zero result, cleared otherwise.
// - Nibble carry flag shows carry out of bit 3 for add/sub.
// - Carry flag shows carry out of bit 7 for add/sub.
// - In subtraction carry flags act as inverted borrows.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out.
// - Status sits at the same location in either bank.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "status_defines.vh"

module cpu_status_flags (
  input wire ref_clk,
  input wire rst_n,
  input wire exec_valid,
  input wire [3:0] exec_op,
  input wire [7:0] exec_w,
  input wire [7:0] exec_src,
  input wire [6:0] exec_faddr,
  input wire [2:0] exec_bit,
  input wire exec_to_file,
  input wire watchdog_timeout,
  output reg [7:0] status_q,
  output reg [7:0] result_q,
  output reg [7:0] phys_addr_q,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  wire file_op;
  wire status_sel;
  wire [7:0] src_val;
  wire [7:0] alu_result;
  wire alu_zero;
  wire alu_nibble;
  wire alu_carry;
  wire upd_zero;
  wire upd_arith;
  wire upd_carry;
  wire wr_status;
  wire flag_op;

  assign file_op = !(exec_op == `OP_ADD_LIT || exec_op == `OP_SUB_LIT ||
                     exec_op == `OP_KICK || exec_op == `OP_SLEEP);
  // Low seven bits only, so both banks reach it
  assign status_sel = (exec_faddr == `STATUS_LOC);
  // The file copy of status lives here, not in core memory
  assign src_val = (file_op && status_sel) ? status_q : exec_src;
  assign wr_status = exec_valid && exec_to_file && file_op &&
                     status_sel;
  // Any op that owns a flag locks the low three bits against data
  assign flag_op = upd_zero || upd_arith || upd_carry;

  status_alu alu_i (
    .op(exec_op),
    .w_val(exec_w),
    .src_val(src_val),
    .bit_sel(exec_bit),
    .carry_in(status_q[`ST_CARRY]),
    .result(alu_result),
    .zero_val(alu_zero),
    .nibble_val(alu_nibble),
    .carry_val(alu_carry),
    .upd_zero(upd_zero),
    .upd_arith(upd_arith),
    .upd_carry(upd_carry)
  );

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  reg aw_held_q;
  reg aw_held_d;
  reg [3:0] aw_addr_q;
  reg [3:0] aw_addr_d;
  reg w_held_q;
  reg w_held_d;
  reg [7:0] w_data_q;
  reg [7:0] w_data_d;
  reg w_strb_q;
  reg w_strb_d;
  reg aw_take;
  reg w_take;
  reg bus_write;
  reg aw_hi_zero_q;
  reg aw_hi_zero_d;

  always @* begin
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    aw_hi_zero_d = aw_hi_zero_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bus_write = 1'b0;
    if (aw_take) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr[3:0];
      aw_hi_zero_d = (s_axi_awaddr[31:4] == 28'h000_0000);
    end
    if (w_take) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_strb_d = s_axi_wstrb[0];
    end
    // Commit once both halves are in and the response slot is free
    if (aw_held_q && w_held_q && !s_axi_bvalid) begin
      bus_write = 1'b1;
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
    end
  end

  wire bus_status_hit;
  wire bus_result_hit;
  assign bus_status_hit = aw_hi_zero_q && (aw_addr_q == `REG_STATUS);
  assign bus_result_hit = aw_hi_zero_q && (aw_addr_q == `REG_RESULT);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      aw_hi_zero_q <= 1'b0;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      aw_hi_zero_q <= aw_hi_zero_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      // Ready drops for the beat after a take, so nothing slips past
      s_axi_awready <= !aw_held_d && !aw_take && !s_axi_awready;
      s_axi_wready <= !w_held_d && !w_take && !s_axi_wready;
      if (bus_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (bus_status_hit || bus_result_hit) ?
                       `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;

  always @* begin
    rdata_d = `ZERO_WORD;
    rresp_d = `RESP_OKAY;
    if (s_axi_araddr[31:4] != 28'h000_0000) begin
      rresp_d = `RESP_SLVERR;
    end else if (s_axi_araddr[3:0] == `REG_STATUS) begin
      rdata_d = {24'h00_0000, status_q};
    end else if (s_axi_araddr[3:0] == `REG_RESULT) begin
      rdata_d = {24'h00_0000, result_q};
    end else begin
      rresp_d = `RESP_SLVERR;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `ZERO_WORD;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rresp_d;
      end else begin
        if (s_axi_rvalid && s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      end
    end
  end

  // ****************************************************************
  // Status register update
  // ****************************************************************
  reg [7:0] status_d;
  reg [7:0] result_d;

  always @* begin
    status_d = status_q;
    result_d = result_q;
    // Bus write is lowest priority; a same-cycle instruction wins
    if (bus_write && bus_status_hit && w_strb_q) begin
      // Timeout and power-down bits are not writable
      status_d = {w_data_q[`ST_RSV_UPPER:`ST_BANK],
                  status_q[`ST_TIMEOUT:`ST_PWRDN],
                  w_data_q[`ST_ZERO:`ST_CARRY]};
    end
    if (exec_valid) begin
      result_d = alu_result;
      if (wr_status) begin
        // Bits 7..6 are stored as written and steer nothing
        status_d = {alu_result[`ST_RSV_UPPER:`ST_BANK],
                    status_q[`ST_TIMEOUT:`ST_PWRDN],
                    alu_result[`ST_ZERO:`ST_CARRY]};
        // Data never reaches the low three bits of a flag-setting op
        if (flag_op) begin
          status_d[`ST_ZERO:`ST_CARRY] =
            status_q[`ST_ZERO:`ST_CARRY];
        end
      end
      // Hardware flags override the destination write
      if (upd_zero) begin
        status_d[`ST_ZERO] = alu_zero;
      end
      if (upd_arith) begin
        status_d[`ST_NIBBLE] = alu_nibble;
      end
      if (upd_carry) begin
        status_d[`ST_CARRY] = alu_carry;
      end
      if (exec_op == `OP_KICK) begin
        status_d[`ST_TIMEOUT] = 1'b1;
        status_d[`ST_PWRDN] = 1'b1;
      end
      if (exec_op == `OP_SLEEP) begin
        status_d[`ST_TIMEOUT] = 1'b1;
        status_d[`ST_PWRDN] = 1'b0;
      end
    end
    // A time-out in the same cycle as a kick is still recorded
    if (watchdog_timeout) begin
      status_d[`ST_TIMEOUT] = 1'b0;
    end
  end

  // Power-up value: timeout and power-down set, bank 0
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `STATUS_RESET;
      result_q <= `RESULT_RESET;
    end else begin
      status_q <= status_d;
      result_q <= result_d;
    end
  end

  // ****************************************************************
  // Direct addressing bank select
  // ****************************************************************
  // Uses the bank bit in force when the instruction issues
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phys_addr_q <= 8'h00;
    end else begin
      phys_addr_q <= {status_q[`ST_BANK], exec_faddr};
    end
  end

endmodule

// ### hdl/status_alu.v
// Purpose: Combinational result and flag generation for one instruction
// Assumes: Operands already selected by the caller
// Notes: Outputs are unregistered; the caller registers them
`timescale 1ns/1ps
`include "status_defines.vh"

module status_alu (
  input wire [3:0] op,
  input wire [7:0] w_val,
  input wire [7:0] src_val,
  input wire [2:0] bit_sel,
  input wire carry_in,
  output reg [7:0] result,
  output reg zero_val,
  output reg nibble_val,
  output reg carry_val,
  output reg upd_zero,
  output reg upd_arith,
  output reg upd_carry
);

  // ****************************************************************
  // Adder shared by add and subtract
  // ****************************************************************
  reg [7:0] addend;
  reg [7:0] other;
  reg cin;
  reg [4:0] low_sum;
  reg [8:0] full_sum;
  reg [7:0] bit_mask;

  always @* begin
    addend = src_val;
    other = w_val;
    cin = 1'b0;
    // Two's complement of the second operand
    if (op == `OP_SUB_LIT || op == `OP_SUB_FILE) begin
      other = ~w_val;
      cin = 1'b1;
    end
    low_sum = {1'b0, addend[3:0]} + {1'b0, other[3:0]} + {4'h0, cin};
    full_sum = {1'b0, addend} + {1'b0, other} + {8'h00, cin};
    bit_mask = 8'h01 << bit_sel;
    result = src_val;
    zero_val = 1'b0;
    nibble_val = low_sum[4];
    carry_val = full_sum[8];
    upd_zero = 1'b0;
    upd_arith = 1'b0;
    upd_carry = 1'b0;
    case (op)
      `OP_ADD_FILE, `OP_ADD_LIT, `OP_SUB_LIT, `OP_SUB_FILE: begin
        result = full_sum[7:0];
        upd_zero = 1'b1;
        upd_arith = 1'b1;
        upd_carry = 1'b1;
      end
      `OP_AND_FILE: begin
        result = src_val & w_val;
        upd_zero = 1'b1;
      end
      `OP_OR_FILE: begin
        result = src_val | w_val;
        upd_zero = 1'b1;
      end
      `OP_XOR_FILE: begin
        result = src_val ^ w_val;
        upd_zero = 1'b1;
      end
      `OP_CLEAR: begin
        result = 8'h00;
        upd_zero = 1'b1;
      end
      // These leave every arithmetic flag alone
      `OP_BIT_CLR: result = src_val & ~bit_mask;
      `OP_BIT_SET: result = src_val | bit_mask;
      `OP_SWAP: result = {src_val[3:0], src_val[7:4]};
      `OP_MOVE: result = w_val;
      `OP_ROT_RIGHT: begin
        result = {carry_in, src_val[7:1]};
        carry_val = src_val[0];
        upd_carry = 1'b1;
      end
      `OP_ROT_LEFT: begin
        result = {src_val[6:0], carry_in};
        carry_val = src_val[7];
        upd_carry = 1'b1;
      end
      default: result = src_val;
    endcase
    zero_val = (result == 8'h00);
  end

endmodule

// ### hdl/status_defines.vh
// Purpose: Shared constants of the status flag block
// Assumes: Included by bare name from every design file
// Notes: Definitions only
`ifndef STATUS_DEFINES_VH
`define STATUS_DEFINES_VH

// ****************************************************************
// Status bit positions
// ****************************************************************
`define ST_RSV_UPPER 7
`define ST_RSV_HIGH 6
`define ST_BANK 5
`define ST_TIMEOUT 4
`define ST_PWRDN 3
`define ST_ZERO 2
`define ST_NIBBLE 1
`define ST_CARRY 0

// ****************************************************************
// Reset values and data memory map
// ****************************************************************
`define STATUS_RESET 8'h18
`define RESULT_RESET 8'h00
`define STATUS_LOC 7'h03

// ****************************************************************
// Instruction codes
// ****************************************************************
`define OP_ADD_FILE 4'h0
`define OP_ADD_LIT 4'h1
`define OP_SUB_LIT 4'h2
`define OP_SUB_FILE 4'h3
`define OP_AND_FILE 4'h4
`define OP_OR_FILE 4'h5
`define OP_XOR_FILE 4'h6
`define OP_CLEAR 4'h7
`define OP_BIT_CLR 4'h8
`define OP_BIT_SET 4'h9
`define OP_SWAP 4'ha
`define OP_MOVE 4'hb
`define OP_ROT_RIGHT 4'hc
`define OP_ROT_LEFT 4'hd
`define OP_KICK 4'he
`define OP_SLEEP 4'hf

// ****************************************************************
// AXI4-Lite register map and answers
// ****************************************************************
`define REG_STATUS 4'h0
`define REG_RESULT 4'h4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define ZERO_WORD 32'h0000_0000

`endif

// ### testbench/cpu_status_flags_bench.sv
// Purpose: Directed tests of the status flag block
// Assumes: 50 MHz clock, registers over AXI4-Lite
// Notes: Plain file ops use location 20h; the bank address checks move to 10h
`timescale 1ns/1ps
module cpu_status_flags_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic exec_valid = 1'b0;
  logic exec_to_file = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic [3:0] exec_op = 4'h0;
  logic [7:0] exec_w = 8'h00;
  logic [7:0] exec_src = 8'h00;
  logic [6:0] exec_faddr = 7'h20;
  logic [2:0] exec_bit = 3'h0;
  logic [7:0] status_q, result_q, phys_addr_q;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int num_checks = 0;

  cpu_status_flags dut (.ref_clk, .rst_n, .exec_valid, .exec_op, .exec_w,
    .exec_src, .exec_faddr, .exec_bit, .exec_to_file, .watchdog_timeout,
    .status_q, .result_q, .phys_addr_q, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #10 ref_clk = ~ref_clk;

  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Bit number rides on the low bits of w
  task automatic run(input logic [3:0] op, input logic [7:0] w, s,
    input logic [6:0] fa, input logic tf);
    @(posedge ref_clk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_w <= w;
    exec_src <= s;
    exec_faddr <= fa;
    exec_to_file <= tf;
    exec_bit <= w[2:0];
    @(posedge ref_clk);
    exec_valid <= 1'b0;
    #1;
  endtask

  task automatic step(input logic [3:0] op, input logic [7:0] w, s, r,
    input logic [2:0] f, m);
    run(op, w, s, 7'h20, 1'b0);
    chk("result", result_q, r);
    chk("flags", status_q[2:0] & m, f & m);
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [3:0] st,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) num_errors++;
    chk("bresp", s_axi_bresp, er);
  endtask

  task automatic rchk(input logic [31:0] a, e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) num_errors++;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("status", status_q, 8'h18);
    rchk(32'h0, 32'h18, 2'b00);
    step(4'h0, 8'h0F, 8'h01, 8'h10, 3'b010, 3'b111);
    step(4'h1, 8'hFF, 8'h01, 8'h00, 3'b111, 3'b111);
    step(4'h8, 8'h06, 8'h5A, 8'h1A, 3'b111, 3'b111);
    step(4'h9, 8'h06, 8'h1A, 8'h5A, 3'b111, 3'b111);
    step(4'ha, 8'h06, 8'h5A, 8'hA5, 3'b111, 3'b111);
    step(4'hb, 8'h06, 8'h5A, 8'h06, 3'b111, 3'b111);
    step(4'h2, 8'h05, 8'h03, 8'hFE, 3'b000, 3'b111);
    step(4'h3, 8'h05, 8'h05, 8'h00, 3'b111, 3'b111);
    step(4'h4, 8'h0F, 8'hF0, 8'h00, 3'b100, 3'b100);
    step(4'h5, 8'h0F, 8'hF0, 8'hFF, 3'b000, 3'b100);
    step(4'h6, 8'h0F, 8'h0F, 8'h00, 3'b100, 3'b100);
    step(4'hc, 8'h00, 8'h02, 8'h81, 3'b000, 3'b001);
    step(4'hd, 8'h00, 8'h80, 8'h00, 3'b001, 3'b001);
    run(4'hb, 8'h27, 8'h00, 7'h03, 1'b1);
    chk("status", status_q, 8'h3F);
    run(4'hb, 8'h00, 8'h00, 7'h10, 1'b1);
    chk("bank addr", phys_addr_q, 8'h90);
    run(4'h0, 8'h01, 8'h00, 7'h03, 1'b1);
    chk("status", status_q, 8'h5A);
    run(4'h7, 8'h00, 8'h00, 7'h03, 1'b1);
    chk("status", status_q, 8'h1E);
    run(4'hb, 8'h00, 8'h00, 7'h10, 1'b1);
    chk("bank addr", phys_addr_q, 8'h10);
    run(4'hd, 8'h00, 8'h00, 7'h03, 1'b1);
    chk("status", status_q, 8'h3E);
    wr(32'h0, 32'h07, 4'hF, 2'b00);
    rchk(32'h0, 32'h1F, 2'b00);
    wr(32'h0, 32'h00, 4'hE, 2'b00);
    rchk(32'h0, 32'h1F, 2'b00);
    run(4'hf, 8'h00, 8'h00, 7'h20, 1'b0);
    chk("status", status_q, 8'h17);
    @(posedge ref_clk);
    watchdog_timeout <= 1'b1;
    @(posedge ref_clk);
    watchdog_timeout <= 1'b0;
    #1;
    chk("status", status_q, 8'h07);
    wr(32'h0, 32'h18, 4'hF, 2'b00);
    rchk(32'h0, 32'h00, 2'b00);
    run(4'he, 8'h00, 8'h00, 7'h20, 1'b0);
    chk("status", status_q, 8'h18);
    step(4'h1, 8'h12, 8'h21, 8'h33, 3'b000, 3'b111);
    wr(32'h8, 32'h00, 4'hF, 2'b10);
    rchk(32'h8, 32'h00, 2'b10);
    wr(32'h4, 32'hFF, 4'hF, 2'b00);
    rchk(32'h4, 32'h33, 2'b00);
    finish_test;
  end

  // Run needs well under 2000 cycles
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
endmodule

// ### testbench/cpu_status_flags_props.sv
// Purpose: Port assertions for the status flag block
// Assumes: Bus writes and file ops on 03h kept apart by the bench
// Notes: Add, subtract, rotate and keep-flag checks skip location 03h, where data competes
`timescale 1ns/1ps
module cpu_status_flags_props (
  input logic ref_clk,
  input logic rst_n,
  input logic exec_valid,
  input logic [3:0] exec_op,
  input logic [7:0] exec_w,
  input logic [7:0] exec_src,
  input logic [6:0] exec_faddr,
  input logic exec_to_file,
  input logic watchdog_timeout,
  input logic [7:0] status_q,
  input logic [7:0] phys_addr_q,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready
);
  // ****
  // Reference sums
  // ****
  logic idle;
  logic offer_q;
  logic ord;
  logic [8:0] add9;
  logic [8:0] sub9;
  logic [4:0] addn;
  logic [4:0] subn;
  // A write commits the edge after its last take, so look one edge back
  always @(posedge ref_clk) begin
    offer_q <= s_axi_awvalid || s_axi_wvalid;
  end
  assign idle = !offer_q && !s_axi_awvalid && !s_axi_wvalid
    && !s_axi_bvalid;
  assign ord = exec_valid && exec_faddr != 7'h03;
  assign add9 = {1'b0, exec_src} + {1'b0, exec_w};
  assign addn = {1'b0, exec_src[3:0]} + {1'b0, exec_w[3:0]};
  assign sub9 = {1'b0, exec_src} + {1'b0, ~exec_w} + 9'h001;
  assign subn = {1'b0, exec_src[3:0]} + {1'b0, ~exec_w[3:0]} + 5'h01;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  kick_flags_a: assert property (
    exec_valid && exec_op == 4'he && !watchdog_timeout
    |=> status_q[4:3] == 2'b11)
    else $error("Kick left flags wrong");
  sleep_flags_a: assert property (
    exec_valid && exec_op == 4'hf && !watchdog_timeout
    |=> status_q[4:3] == 2'b10)
    else $error("Sleep left flags wrong");
  timeout_clear_a: assert property (
    watchdog_timeout |=> !status_q[4])
    else $error("Time-out did not clear flag");
  add_flags_a: assert property (
    ord && exec_op <= 4'h1 |=> status_q[2:0] ==
    $past({add9[7:0] == 8'h00, addn[4], add9[8]}))
    else $error("Add flags wrong");
  sub_flags_a: assert property (
    ord && exec_op[3:1] == 3'b001 |=> status_q[2:0] ==
    $past({sub9[7:0] == 8'h00, subn[4], sub9[8]}))
    else $error("Subtract flags wrong");
  rotate_carry_a: assert property (
    ord && exec_op[3:1] == 3'b110 |=> status_q[0] ==
    $past(exec_op[0] ? exec_src[7] : exec_src[0]))
    else $error("Rotate carry wrong");
  keep_flags_a: assert property (
    ord && idle && exec_op[3:2] == 2'b10 |=> $stable(status_q[2:0]))
    else $error("Bit or move op changed flags");
  clear_status_a: assert property (
    exec_valid && idle && !watchdog_timeout && exec_op == 4'h7 && exec_to_file
    && exec_faddr == 7'h03 |=> status_q[7:5] == 3'h0 && status_q[2]
    && $stable({status_q[4:3], status_q[1:0]}))
    else $error("Clear of status wrong");
  bank_addr_a: assert property (
    1'b1 |=> phys_addr_q == {$past(status_q[5]), $past(exec_faddr)})
    else $error("Bank address wrong");

  cover property (exec_valid && exec_op == 4'h7 && exec_faddr == 7'h03);
  cover property (watchdog_timeout);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind cpu_status_flags cpu_status_flags_props props_i (.ref_clk, .rst_n,
  .exec_valid, .exec_op, .exec_w, .exec_src, .exec_faddr, .exec_to_file,
  .watchdog_timeout, .status_q, .phys_addr_q, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready);
